// *** rtl/adcctr_pkg.sv ***
`default_nettype none
package adcctr_pkg;
  // Register byte offsets.
  localparam logic [7:0] ADDR_GAIN_SCALE   = 8'h24;
  localparam logic [7:0] ADDR_OFFSET_TRIM  = 8'h26;
  localparam logic [7:0] ADDR_ANALOG_TRIM  = 8'h28;
  localparam logic [7:0] ADDR_DEBUG_HALT   = 8'h2a;
  // Field positions and widths.
  localparam int unsigned CORR_W           = 12;
  localparam int unsigned TRIM_W           = 11;
  localparam int unsigned RUN_HALTED_BIT   = 0;
  // Values after reset.
  localparam logic [11:0] GAIN_RESET       = 12'h000;
  localparam logic [11:0] OFFSET_RESET     = 12'h000;
  localparam logic [10:0] TRIM_RESET       = 11'h000;
  localparam logic        RUN_HALT_RESET   = 1'b0;
  // Fraction bits of the gain factor.
  localparam int unsigned GAIN_FRAC        = 11;
  localparam logic [11:0] RESULT_MAX       = 12'hfff;
endpackage
`default_nettype wire

// *** rtl/adcctr_corr.sv ***
`timescale 1ns/1ps
`default_nettype none
// Combinational correction datapath: (raw - offset) * gain, saturated.
module adcctr_corr
  import adcctr_pkg::*;
(
  // Operands.
  input  wire logic [11:0] raw_i,
  input  wire logic [11:0] gain_i,
  input  wire logic [11:0] offset_i,
  // Result.
  output logic      [11:0] corr_o
);
  logic signed [13:0] diff;
  logic signed [26:0] prod;
  logic signed [26:0] scaled;

  // Signed offset is sign extended so it may shift either way.
  always_comb
  begin
    diff   = $signed({2'h0, raw_i}) - $signed({{2{offset_i[11]}}, offset_i});
    prod   = 27'(diff) * $signed({15'h0, gain_i});
    scaled = prod >>> GAIN_FRAC;
    // Clamp to the unsigned result range.
    if (scaled < 0)
      corr_o = 12'h000;
    else if (scaled > $signed({15'h0, RESULT_MAX}))
      corr_o = RESULT_MAX;
    else
      corr_o = scaled[11:0];
  end
endmodule
`default_nettype wire

// *** rtl/adcctr_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Correction on: scale raw by gain.
// - Gain is unsigned 1.11 fixed point.
// - Correction on: subtract offset from raw.
// - Offset is signed two's complement.
// - Reserved upper bits read back zero.
// - Halted debug: stop unless run bit set.
// - Run bit changes only while disabled.
// - Result sits in bits 11:0 of 16.
module adcctr_regs
  import adcctr_pkg::*;
(
  // Clock and reset.
  input  wire logic        core_clk_i,
  input  wire logic        resetn_i,
  // Register port.
  input  wire logic [7:0]  addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [15:0] rdata_o,
  // Converter side.
  input  wire logic        correction_on_i,
  input  wire logic        adc_enabled_i,
  input  wire logic        write_guard_i,
  input  wire logic        cpu_halted_i,
  input  wire logic        raw_valid_i,
  input  wire logic [11:0] raw_i,
  output logic      [15:0] result_o,
  output logic             result_valid_o,
  output logic             adc_run_o,
  output logic      [10:0] analog_trim_o
);
  typedef struct packed {
    logic [11:0] gain;
    logic [11:0] offset;
    logic [10:0] trim;
    logic        run_halted;
    logic [15:0] rdata;
    logic [15:0] result;
    logic        rvalid;
    logic        run;
  } adcctr_state_t;

  adcctr_state_t st;
  adcctr_state_t next_st;
  logic [11:0]   corr;
  logic          wr_ok;

  adcctr_corr u_corr
  (
    .raw_i    (raw_i),
    .gain_i   (st.gain),
    .offset_i (st.offset),
    .corr_o   (corr)
  );

  assign wr_ok = wr_i && !write_guard_i;

  // Next state: register writes, read mux, result capture, run gating.
  always_comb
  begin
    next_st = st;
    if (wr_ok)
    begin
      case (addr_i)
        ADDR_GAIN_SCALE:  next_st.gain   = wdata_i[11:0];
        ADDR_OFFSET_TRIM: next_st.offset = wdata_i[11:0];
        ADDR_ANALOG_TRIM: next_st.trim   = wdata_i[10:0];
        ADDR_DEBUG_HALT:
        begin
          // Changing it mid-run could halt a conversion unpredictably.
          if (!adc_enabled_i)
            next_st.run_halted = wdata_i[RUN_HALTED_BIT];
        end
        default: next_st.gain = st.gain;
      endcase
    end
    // Reads answer the cycle after; unmapped addresses read zero.
    next_st.rdata = 16'h0000;
    if (rd_i)
    begin
      case (addr_i)
        ADDR_GAIN_SCALE:  next_st.rdata = {4'h0, st.gain};
        ADDR_OFFSET_TRIM: next_st.rdata = {4'h0, st.offset};
        ADDR_ANALOG_TRIM: next_st.rdata = {5'h00, st.trim};
        ADDR_DEBUG_HALT:  next_st.rdata = {15'h0000, st.run_halted};
        default:          next_st.rdata = 16'h0000;
      endcase
    end
    // Converter halts in debug unless told to keep running.
    next_st.run = adc_enabled_i && (!cpu_halted_i || st.run_halted);
    next_st.rvalid = 1'b0;
    if (raw_valid_i && st.run)
    begin
      next_st.rvalid = 1'b1;
      if (correction_on_i)
        next_st.result = {4'h0, corr};
      else
        next_st.result = {4'h0, raw_i};
    end
  end

  // State register.
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      st            <= '0;
      st.gain       <= GAIN_RESET;
      st.offset     <= OFFSET_RESET;
      st.trim       <= TRIM_RESET;
      st.run_halted <= RUN_HALT_RESET;
    end
    else
      st <= next_st;
  end

  assign rdata_o        = st.rdata;
  assign result_o       = st.result;
  assign result_valid_o = st.rvalid;
  assign adc_run_o      = st.run;
  assign analog_trim_o  = st.trim;

  // Guarded writes leave the gain untouched.
  property p_guard;
    @(posedge core_clk_i) disable iff (!resetn_i)
      (wr_i && write_guard_i) |=> $stable(st.gain) && $stable(st.run_halted);
  endproperty
  a_guard: assert property (p_guard) else $error("guarded write changed a register");

  property p_run_locked;
    @(posedge core_clk_i) disable iff (!resetn_i)
      adc_enabled_i |=> $stable(st.run_halted);
  endproperty
  a_run_locked: assert property (p_run_locked) else $error("run bit changed while enabled");

  property p_halt;
    @(posedge core_clk_i) disable iff (!resetn_i)
      (cpu_halted_i && !st.run_halted) |=> !adc_run_o;
  endproperty
  a_halt: assert property (p_halt) else $error("converter ran while halted");

  property p_keep_run;
    @(posedge core_clk_i) disable iff (!resetn_i)
      (adc_enabled_i && st.run_halted && !wr_i) |=> adc_run_o;
  endproperty
  a_keep_run: assert property (p_keep_run) else $error("converter stopped with run bit set");

  property p_upper_zero;
    @(posedge core_clk_i) disable iff (!resetn_i)
      result_o[15:12] == 4'h0;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("result upper bits set");

  property p_rsv_rd;
    @(posedge core_clk_i) disable iff (!resetn_i)
      (rd_i && addr_i == ADDR_ANALOG_TRIM) |=> rdata_o[15:11] == 5'h00;
  endproperty
  a_rsv_rd: assert property (p_rsv_rd) else $error("reserved trim bits read nonzero");

  property p_gain_wr;
    @(posedge core_clk_i) disable iff (!resetn_i)
      (wr_ok && addr_i == ADDR_GAIN_SCALE) ##1 (rd_i && addr_i == ADDR_GAIN_SCALE)
        |=> rdata_o == {4'h0, $past(wdata_i[11:0], 2)};
  endproperty
  a_gain_wr: assert property (p_gain_wr) else $error("gain readback mismatch");

  property p_raw_pass;
    @(posedge core_clk_i) disable iff (!resetn_i)
      (raw_valid_i && st.run && !correction_on_i) |=> result_o == {4'h0, $past(raw_i)};
  endproperty
  a_raw_pass: assert property (p_raw_pass) else $error("uncorrected result mismatch");

  property p_corr;
    @(posedge core_clk_i) disable iff (!resetn_i)
      (raw_valid_i && st.run && correction_on_i) |=> result_o == {4'h0, $past(corr)};
  endproperty
  a_corr: assert property (p_corr) else $error("corrected result mismatch");

  // Reserved upper bits of the correction registers read zero.
  property p_rsv_corr;
    @(posedge core_clk_i) disable iff (!resetn_i)
      (rd_i && (addr_i == ADDR_GAIN_SCALE || addr_i == ADDR_OFFSET_TRIM))
        |=> rdata_o[15:12] == 4'h0;
  endproperty
  a_rsv_corr: assert property (p_rsv_corr) else $error("correction reserved bits set");

  // Only bit 0 of the debug register is live.
  property p_rsv_dbg;
    @(posedge core_clk_i) disable iff (!resetn_i)
      (rd_i && addr_i == ADDR_DEBUG_HALT) |=> rdata_o[15:1] == 15'h0000;
  endproperty
  a_rsv_dbg: assert property (p_rsv_dbg) else $error("debug reserved bits set");

  // Read data stand one cycle only, so a stale word is never taken for a fresh one.
  property p_rd_idle;
    @(posedge core_clk_i) disable iff (!resetn_i)
      !rd_i |=> rdata_o == 16'h0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read cycle");

  // A stopped converter stores nothing: no valid pulse and no new result.
  property p_valid_gate;
    @(posedge core_clk_i) disable iff (!resetn_i)
      !(raw_valid_i && st.run) |=> !result_valid_o;
  endproperty
  a_valid_gate: assert property (p_valid_gate) else $error("result valid without capture");

  property p_result_hold;
    @(posedge core_clk_i) disable iff (!resetn_i)
      !(raw_valid_i && st.run) |=> $stable(result_o);
  endproperty
  a_result_hold: assert property (p_result_hold) else $error("result changed without capture");

  // The trim output follows an accepted write on the next cycle.
  property p_trim_wr;
    @(posedge core_clk_i) disable iff (!resetn_i)
      (wr_ok && addr_i == ADDR_ANALOG_TRIM) |=> analog_trim_o == $past(wdata_i[10:0]);
  endproperty
  a_trim_wr: assert property (p_trim_wr) else $error("trim output mismatch");

  // Main scenarios: corrected capture, running while halted, blocked and locked writes.
  c_corr:  cover property (@(posedge core_clk_i) raw_valid_i && st.run && correction_on_i);
  c_halt:  cover property (@(posedge core_clk_i) cpu_halted_i && st.run_halted && adc_run_o);
  c_guard: cover property (@(posedge core_clk_i) wr_i && write_guard_i);
  c_lock:  cover property (@(posedge core_clk_i) adc_enabled_i && wr_ok && addr_i == ADDR_DEBUG_HALT);
endmodule
`default_nettype wire

// *** testbench/adc_correction_trim_debug_regs_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module adc_correction_trim_debug_regs_tb_top
  import adcctr_pkg::*;
;
  logic        core_clk;
  logic        resetn;
  logic [7:0]  addr;
  logic [15:0] wdata;
  logic        wr;
  logic        rd;
  logic [15:0] rdata;
  logic        corr_on;
  logic        adc_en;
  logic        guard;
  logic        halted;
  logic        raw_valid;
  logic [11:0] raw;
  logic [15:0] result;
  logic        result_valid;
  logic        adc_run;
  logic [10:0] trim;
  int          errors;
  int          compares;
  int          cycles;
  // Gain, offset and raw value of each correction case; the third clamps high, the fourth low.
  logic [35:0] cases [0:4] = '{36'h800000123, 36'h400ff0100, 36'hfff000fff,
                               36'h800010005, 36'h7ff800000};
  // Results worked out by hand from the fixed-point rules.
  logic [15:0] exp_res [0:4] = '{16'h0123, 16'h0088, 16'h0fff, 16'h0000, 16'h07ff};

  adcctr_regs uut (.core_clk_i(core_clk), .resetn_i(resetn), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .correction_on_i(corr_on),
    .adc_enabled_i(adc_en), .write_guard_i(guard), .cpu_halted_i(halted),
    .raw_valid_i(raw_valid), .raw_i(raw), .result_o(result), .result_valid_o(result_valid),
    .adc_run_o(adc_run), .analog_trim_o(trim));

  // Free-running clock at 20 MHz.
  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // Cycle ceiling so that a hung handshake still reaches the verdict.
  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      errors = errors + 1;
      end_of_test();
    end
  end

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    compares = compares + 1;
    if (got !== exp)
    begin
      errors = errors + 1;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge core_clk);
    wr    <= 1'b0;
  endtask

  // Write, then read the same register at the very next edge, with no gap.
  task automatic wr_rd(input logic [7:0] a, input logic [15:0] d, input logic [15:0] exp);
    @(posedge core_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge core_clk);
    wr    <= 1'b0;
    rd    <= 1'b1;
    @(posedge core_clk);
    rd    <= 1'b0;
    #1 chk("rdata", exp, rdata);
  endtask

  // Read data stand only in the cycle after the strobe, so they are sampled there.
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    @(posedge core_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge core_clk);
    rd   <= 1'b0;
    #1 chk("rdata", exp, rdata);
  endtask

  // The run state lags its inputs by a cycle, so two edges pass before it is looked at.
  task automatic set_ctl(input logic en, input logic halt, input logic exp_run);
    @(posedge core_clk);
    adc_en <= en;
    halted <= halt;
    repeat (2) @(posedge core_clk);
    #1 chk("adc_run", {15'h0, exp_run}, {15'h0, adc_run});
  endtask

  task automatic conv(input logic [11:0] r, input logic exp_v, input logic [15:0] exp);
    @(posedge core_clk);
    raw_valid <= 1'b1;
    raw       <= r;
    @(posedge core_clk);
    raw_valid <= 1'b0;
    #1 chk("result_valid", {15'h0, exp_v}, {15'h0, result_valid});
    chk("result", exp, result);
  endtask

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Main sequence.
  initial
  begin
    {addr, wdata, wr, rd, corr_on, adc_en, guard, halted, raw_valid, raw} = '0;
    {errors, compares, cycles} = '0;
    resetn = 1'b0;
    repeat (6) @(posedge core_clk);
    resetn <= 1'b1;
    for (int i = 0; i < 5; i++)
      rd_chk(8'h24 + 8'(2 * i), 16'h0000);
    $display("Test reset values done");
    wr_reg(8'h24, 16'h0fff);
    wr_reg(8'h26, 16'h0fff);
    wr_reg(8'h28, 16'h07ff);
    wr_reg(8'h2a, 16'h0001);
    wr_reg(8'h2c, 16'hffff);
    rd_chk(8'h24, 16'h0fff);
    rd_chk(8'h26, 16'h0fff);
    rd_chk(8'h28, 16'h07ff);
    rd_chk(8'h2a, 16'h0001);
    rd_chk(8'h2c, 16'h0000);
    chk("analog_trim", 16'h07ff, {5'h0, trim});
    $display("Test reserved bits done");
    @(posedge core_clk);
    guard <= 1'b1;
    for (int i = 0; i < 4; i++)
      wr_reg(8'h24 + 8'(2 * i), 16'h0000);
    guard <= 1'b0;
    rd_chk(8'h24, 16'h0fff);
    rd_chk(8'h26, 16'h0fff);
    rd_chk(8'h28, 16'h07ff);
    rd_chk(8'h2a, 16'h0001);
    $display("Test write guard done");
    set_ctl(1'b1, 1'b1, 1'b1);
    wr_reg(8'h2a, 16'h0000);
    rd_chk(8'h2a, 16'h0001);
    set_ctl(1'b0, 1'b1, 1'b0);
    wr_reg(8'h2a, 16'h0000);
    set_ctl(1'b1, 1'b1, 1'b0);
    conv(12'h0aa, 1'b0, 16'h0000);
    set_ctl(1'b1, 1'b0, 1'b1);
    $display("Test debug run done");
    conv(12'h345, 1'b1, 16'h0345);
    @(posedge core_clk);
    corr_on <= 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      wr_rd(8'h24, {4'h0, cases[i][35:24]}, {4'h0, cases[i][35:24]});
      wr_reg(8'h26, {4'h0, cases[i][23:12]});
      conv(cases[i][11:0], 1'b1, exp_res[i]);
    end
    $display("Test correction done");
    // A second reset in mid-run must bring every register back to zero.
    @(posedge core_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    #1 chk("result", 16'h0000, result);
    chk("analog_trim", 16'h0000, {5'h0, trim});
    rd_chk(8'h24, 16'h0000);
    rd_chk(8'h2a, 16'h0000);
    $display("Test mid-run reset done");
    end_of_test();
  end
endmodule
`default_nettype wire
